/* File: common/ref_offset_pkg.sv */
// package: command codes, field limits, restore values and ramp types for the offset block
package ref_offset_pkg;
    localparam logic [7:0] CMD_TRIM = 8'hd4;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'hd5;
    localparam logic [7:0] CMD_MARGIN_LOW = 8'hd6;
    localparam logic signed [15:0] TRIM_MIN = 16'shffc0;
    localparam logic signed [15:0] TRIM_MAX = 16'sh003f;
    localparam logic signed [15:0] TRIM_RESET = 16'sh0000;
    localparam logic signed [15:0] MHI_MIN = 16'sh0000;
    localparam logic signed [15:0] MHI_MAX = 16'sh001f;
    localparam logic signed [15:0] MHI_RESTORE_0 = 16'sh0009;
    localparam logic signed [15:0] MHI_RESTORE_1 = 16'sh000f;
    localparam logic signed [15:0] MLO_MIN = 16'shffc0;
    localparam logic signed [15:0] MLO_MAX = 16'shffff;
    localparam logic signed [15:0] MLO_RESTORE_0 = 16'shfff7;
    localparam logic signed [15:0] MLO_RESTORE_1 = 16'shfff1;
    localparam int OP_MARGIN_HIGH_BIT = 5;
    localparam int OP_MARGIN_LOW_BIT = 4;
    localparam int REF_W = 18;
    typedef enum logic [1:0] {
        SEQ_SOFT_START,
        SEQ_STEADY,
        SEQ_OFF_DELAY,
        SEQ_SOFT_STOP
    } seq_state_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_req_t;
    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } cmd_rsp_t;
endpackage

/* File: core/reference_offset_registers.sv */
// offset register bank and reference code generator with rate-limited ramp
`timescale 1ns/100ps

// Notes on behaviour
// R1: loop-slave device ignores trim and margin-high writes, contents unchanged.
// R2: loop-slave access is NACKed, flags invalid-access fault and asserts alert.
// R3: reference = nominal*scale + trim + gated margin high + gated margin low.
// R4: format fixed linear exponent -9, one count equals one reference step.
// R5: trim accepted from -64 to +63 counts.
// R6: out-of-range offset writes saturate to the nearest limit.
// R7: out-of-range write asserts alert, summary fault bit and invalid-data bit.
// R8: final reference is bounded by the maximum and minimum output limits.
// R9: ramp rate follows soft-start, steady, off-delay or soft-stop state.
// R10: trim high byte is sign extension only; low byte 0x3f max, 0xc0 min.
// R11: trim resets to zero and is saved on store-all-defaults.
// R12: margin-high selected by operation adds margin-high step to reference.
// R13: margin-high accepts 0 to 31, high byte zero, five writable bits.
// R14: margin-high restores to 9 or 15 by its restore-select bit.
// R15: margin-low selected lowers reference; accepted from -64 to -1.
// R16: margin-low restores to -9 or -15 by its restore-select bit.
// R17: margin restore values load at reset and on defaults reload.
// R18: range checks use the full 16-bit signed value before truncation.
// R19: host uses word transactions, low byte first then high byte.
module reference_offset_registers
    import ref_offset_pkg::*;
#(
    parameter int RATE_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire cmd_req_t req_i,
    input wire logic loop_slave_i,
    input wire logic [7:0] operation_i,
    input wire logic [15:0] vout_command_i,
    input wire logic [3:0] vout_scale_loop_i,
    input wire logic [REF_W-1:0] vout_max_i,
    input wire logic [REF_W-1:0] vout_min_i,
    input wire seq_state_t seq_state_i,
    input wire logic [RATE_W-1:0] rise_interval_i,
    input wire logic [RATE_W-1:0] transition_interval_i,
    input wire logic [RATE_W-1:0] fall_interval_i,
    input wire logic margin_high_restore_select_i,
    input wire logic margin_low_restore_select_i,
    input wire logic store_defaults_i,
    input wire logic restore_defaults_i,
    input wire logic [15:0] nv_trim_i,
    input wire logic status_clear_i,
    output cmd_rsp_t rsp_o,
    output logic nv_store_o,
    output logic [15:0] nv_trim_o,
    output logic alert_o,
    output logic comm_fault_o,
    output logic invalid_data_o,
    output logic invalid_access_fault_o,
    output logic [REF_W-1:0] regulation_reference_o
);
    // ****************************************
    // saturation helper
    // ****************************************
    function automatic logic [15:0] clamp16(input logic signed [15:0] v,
        input logic signed [15:0] lo, input logic signed [15:0] hi);
        if (v < lo) begin
            clamp16 = lo;
        end else if (v > hi) begin
            clamp16 = hi;
        end else begin
            clamp16 = v;
        end
    endfunction

    logic signed [15:0] trim;
    logic signed [15:0] margin_high;
    logic signed [15:0] margin_low;
    logic is_ours;
    logic out_of_range;
    logic wr_ok;
    logic signed [15:0] wdata;
    assign wdata = req_i.data; // R19
    assign is_ours = req_i.valid && (req_i.code == CMD_TRIM || req_i.code == CMD_MARGIN_HIGH
        || req_i.code == CMD_MARGIN_LOW);
    assign wr_ok = is_ours && req_i.write && !loop_slave_i; // R1
    always_comb begin
        out_of_range = 1'b0;
        // full word is checked before truncation
        if (req_i.code == CMD_TRIM) begin
            out_of_range = (wdata < TRIM_MIN) || (wdata > TRIM_MAX); // R5 R18
        end else if (req_i.code == CMD_MARGIN_HIGH) begin
            out_of_range = (wdata < MHI_MIN) || (wdata > MHI_MAX); // R13 R18
        end else if (req_i.code == CMD_MARGIN_LOW) begin
            out_of_range = (wdata < MLO_MIN) || (wdata > MLO_MAX); // R15 R18
        end
    end

    // ****************************************
    // offset registers
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim <= TRIM_RESET; // R11
        end else if (restore_defaults_i) begin
            trim <= clamp16(nv_trim_i, TRIM_MIN, TRIM_MAX);
        end else if (wr_ok && req_i.code == CMD_TRIM) begin
            trim <= clamp16(wdata, TRIM_MIN, TRIM_MAX); // R6 R10
        end
    end

    // restore select bits are only sampled after reset release
    logic restore_pending;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            restore_pending <= 1'b1;
        end else begin
            restore_pending <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            margin_high <= MHI_RESTORE_0;
            margin_low <= MLO_RESTORE_0;
        end else if (restore_pending || restore_defaults_i) begin
            margin_high <= margin_high_restore_select_i ? MHI_RESTORE_1 : MHI_RESTORE_0; // R14 R17
            margin_low <= margin_low_restore_select_i ? MLO_RESTORE_1 : MLO_RESTORE_0; // R16 R17
        end else if (wr_ok && req_i.code == CMD_MARGIN_HIGH) begin
            margin_high <= clamp16(wdata, MHI_MIN, MHI_MAX); // R6 R13
        end else if (wr_ok && req_i.code == CMD_MARGIN_LOW) begin
            margin_low <= clamp16(wdata, MLO_MIN, MLO_MAX); // R6 R15
        end
    end

    // ****************************************
    // nonvolatile save
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_store_o <= 1'b0;
            nv_trim_o <= 16'h0000;
        end else begin
            nv_store_o <= store_defaults_i; // R11
            if (store_defaults_i) begin
                nv_trim_o <= trim;
            end
        end
    end

    // ****************************************
    // response and status
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= is_ours;
            rsp_o.nack <= is_ours && loop_slave_i; // R2
            if (req_i.code == CMD_TRIM) begin
                rsp_o.data <= trim;
            end else if (req_i.code == CMD_MARGIN_HIGH) begin
                rsp_o.data <= margin_high;
            end else begin
                rsp_o.data <= margin_low;
            end
            if (loop_slave_i || req_i.write) begin
                rsp_o.data <= 16'h0000;
            end
        end
    end

    logic set_ivc;
    logic set_bad_data;
    assign set_ivc = is_ours && loop_slave_i;
    assign set_bad_data = wr_ok && out_of_range;
    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            invalid_access_fault_o <= 1'b0;
            invalid_data_o <= 1'b0;
            comm_fault_o <= 1'b0;
            alert_o <= 1'b0;
        end else begin
            invalid_access_fault_o <= set_ivc || (invalid_access_fault_o && !status_clear_i); // R2
            invalid_data_o <= set_bad_data || (invalid_data_o && !status_clear_i); // R7
            comm_fault_o <= set_ivc || set_bad_data || (comm_fault_o && !status_clear_i); // R7
            alert_o <= set_ivc || set_bad_data || (alert_o && !status_clear_i); // R2 R7
        end
    end

    // ****************************************
    // reference target and ramp
    // ****************************************
    // wide enough for full command times largest loop scale, no silent wrap
    logic signed [REF_W+3:0] target_raw;
    logic [REF_W-1:0] target;
    always_comb begin
        // one count is one reference step, no exponent shift needed
        target_raw = $signed({4'h0, vout_command_i}) * $signed({1'b0, vout_scale_loop_i})
            + trim
            + (operation_i[OP_MARGIN_HIGH_BIT] ? margin_high : 16'sh0000)
            + (operation_i[OP_MARGIN_LOW_BIT] ? margin_low : 16'sh0000); // R3 R4 R12 R15
        if (target_raw < $signed({2'b00, vout_min_i})) begin
            target = vout_min_i; // R8
        end else if (target_raw > $signed({2'b00, vout_max_i})) begin
            target = vout_max_i; // R8
        end else begin
            target = target_raw[REF_W-1:0];
        end
    end

    logic [RATE_W-1:0] interval;
    logic [RATE_W-1:0] tick_cnt;
    always_comb begin
        case (seq_state_i)
            SEQ_SOFT_START: interval = rise_interval_i; // R9
            SEQ_SOFT_STOP: interval = fall_interval_i; // R9
            default: interval = transition_interval_i; // R9
        endcase
    end

    // one step every interval+1 clocks keeps the ramp slope independent of distance
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
            regulation_reference_o <= '0;
        end else if (tick_cnt >= interval) begin
            tick_cnt <= '0;
            if (regulation_reference_o < target) begin
                regulation_reference_o <= regulation_reference_o + 1'b1; // R9
            end else if (regulation_reference_o > target) begin
                regulation_reference_o <= regulation_reference_o - 1'b1; // R9
            end
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_slave_nack;
        @(posedge ref_clk_i) disable iff (rst_i)
        (is_ours && loop_slave_i) |=> (rsp_o.nack && alert_o && invalid_access_fault_o);
    endproperty
    a_slave_nack: assert property (p_slave_nack) else $error("slave access not nacked"); // R2
    property p_slave_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (loop_slave_i && !restore_defaults_i && !restore_pending) |=> $stable(trim);
    endproperty
    a_slave_hold: assert property (p_slave_hold) else $error("trim changed on slave"); // R1
    property p_trim_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        (trim >= TRIM_MIN) && (trim <= TRIM_MAX);
    endproperty
    a_trim_range: assert property (p_trim_range) else $error("trim out of range"); // R5
    property p_mhi_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        (margin_high >= MHI_MIN) && (margin_high <= MHI_MAX);
    endproperty
    a_mhi_range: assert property (p_mhi_range) else $error("margin high out of range"); // R13
    property p_bad_write_flag;
        @(posedge ref_clk_i) disable iff (rst_i)
        set_bad_data |=> (invalid_data_o && comm_fault_o && alert_o);
    endproperty
    a_bad_write_flag: assert property (p_bad_write_flag) else $error("bad data not flagged"); // R7
    property p_sat_high;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_ok && req_i.code == CMD_TRIM && wdata > TRIM_MAX && !restore_defaults_i)
            |=> trim == TRIM_MAX;
    endproperty
    a_sat_high: assert property (p_sat_high) else $error("trim not saturated"); // R6
    property p_restore;
        @(posedge ref_clk_i) disable iff (rst_i)
        restore_defaults_i |=> margin_high == ($past(margin_high_restore_select_i)
            ? MHI_RESTORE_1 : MHI_RESTORE_0);
    endproperty
    a_restore: assert property (p_restore) else $error("margin restore wrong"); // R14
    property p_ramp_step;
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(regulation_reference_o) - regulation_reference_o <= 1
            || regulation_reference_o - $past(regulation_reference_o) <= 1;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp step too large"); // R9
    property p_store;
        @(posedge ref_clk_i) disable iff (rst_i)
        store_defaults_i |=> (nv_store_o && nv_trim_o == $past(trim));
    endproperty
    a_store: assert property (p_store) else $error("trim not saved"); // R11
endmodule // reference_offset_registers

/* File: tb/pmbus_host_model.sv */
// host model issuing word commands to the offset block
`timescale 1ns/100ps
module pmbus_host_model
    import ref_offset_pkg::*;
(
    input wire logic ref_clk_i,
    output cmd_req_t req_o,
    input wire cmd_rsp_t rsp_i
);
    initial req_o = '0;
    // one word per request, low byte in data[7:0]
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
        output logic nk, output logic [15:0] rd);
        @(posedge ref_clk_i);
        req_o <= '{valid: 1'b1, write: wr, code: code, data: wd};
        @(posedge ref_clk_i);
        req_o.valid <= 1'b0;
        // released word shows no stale data
        req_o.data <= ~wd;
        @(posedge ref_clk_i);
        nk = rsp_i.valid ? rsp_i.nack : 1'bx;
        rd = rsp_i.data;
    endtask
endmodule // pmbus_host_model

/* File: tb/tb.sv */
// self-checking bench for the reference offset register bank
`timescale 1ns/100ps
module tb;
    import ref_offset_pkg::*;
    logic clk, rst, ls, mhs, mls, sto, rsto, clr, nvs, alrt, cf, idat, invalid_access_fault;
    logic [7:0] op;
    logic [15:0] vcmd, nvt, trn, ri, fi, nvo;
    logic [3:0] vsc;
    logic [17:0] vmax, vmin, rc;
    seq_state_t seq;
    cmd_req_t req;
    cmd_rsp_t rsp;
    int n_fail, n_checks;
    pmbus_host_model u_host(.ref_clk_i(clk), .req_o(req), .rsp_i(rsp));
    reference_offset_registers u_dut(
        .ref_clk_i(clk), .rst_i(rst), .req_i(req), .loop_slave_i(ls),
        .operation_i(op), .vout_command_i(vcmd), .vout_scale_loop_i(vsc),
        .vout_max_i(vmax), .vout_min_i(vmin), .seq_state_i(seq),
        .rise_interval_i(ri), .transition_interval_i(trn), .fall_interval_i(fi),
        .margin_high_restore_select_i(mhs), .margin_low_restore_select_i(mls),
        .store_defaults_i(sto), .restore_defaults_i(rsto), .nv_trim_i(nvt),
        .status_clear_i(clr), .rsp_o(rsp), .nv_store_o(nvs), .nv_trim_o(nvo),
        .alert_o(alrt), .comm_fault_o(cf), .invalid_data_o(idat),
        .invalid_access_fault_o(invalid_access_fault), .regulation_reference_o(rc));
    // ****************
    // helpers
    // ****************
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] wd,
        input logic en, input logic [15:0] er);
        logic nk;
        logic [15:0] rd;
        u_host.xfer(wr, code, wd, nk, rd);
        chk(18'(nk), 18'(en));
        chk(18'(rd), 18'(er));
    endtask
    task automatic flags(input logic [3:0] e);
        @(posedge clk);
        chk(18'({alrt, cf, idat, invalid_access_fault}), 18'(e));
    endtask
    task automatic pulse_clr();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic wait_ref(input logic [17:0] e, input int lim);
        int i;
        for (i = 0; i < lim && rc !== e; i++) @(posedge clk);
        chk(rc, e);
        if (rc !== e) end_of_test();
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        acc(1'b0, CMD_TRIM, 16'h0, 1'b0, 16'h0000);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h0009);
        acc(1'b0, CMD_MARGIN_LOW, 16'h0, 1'b0, 16'hfff7);
        flags(4'h0);
    endtask
    task automatic t_trim();
        acc(1'b1, CMD_TRIM, 16'hffc0, 1'b0, 16'h0);
        acc(1'b0, CMD_TRIM, 16'h0, 1'b0, 16'hffc0);
        flags(4'h0);
        acc(1'b1, CMD_TRIM, 16'h0050, 1'b0, 16'h0);
        acc(1'b0, CMD_TRIM, 16'h0, 1'b0, 16'h003f);
        flags(4'b1110);
        pulse_clr();
        acc(1'b1, CMD_TRIM, 16'hff00, 1'b0, 16'h0);
        acc(1'b0, CMD_TRIM, 16'h0, 1'b0, 16'hffc0);
        pulse_clr();
    endtask
    task automatic t_mhi();
        acc(1'b1, CMD_MARGIN_HIGH, 16'h001f, 1'b0, 16'h0);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h001f);
        acc(1'b1, CMD_MARGIN_HIGH, 16'h0020, 1'b0, 16'h0);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h001f);
        flags(4'b1110);
        pulse_clr();
        acc(1'b1, CMD_MARGIN_HIGH, 16'hffff, 1'b0, 16'h0);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h0000);
        acc(1'b1, CMD_MARGIN_LOW, 16'h0000, 1'b0, 16'h0);
        acc(1'b0, CMD_MARGIN_LOW, 16'h0, 1'b0, 16'hffff);
        flags(4'b1110);
        acc(1'b1, CMD_MARGIN_LOW, 16'hfff7, 1'b0, 16'h0);
        acc(1'b0, CMD_MARGIN_LOW, 16'h0, 1'b0, 16'hfff7);
        pulse_clr();
    endtask
    task automatic t_slave();
        ls <= 1'b1;
        acc(1'b1, CMD_MARGIN_HIGH, 16'h0003, 1'b1, 16'h0);
        acc(1'b0, CMD_TRIM, 16'h0, 1'b1, 16'h0);
        ls <= 1'b0;
        flags(4'b1101);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h0000);
        pulse_clr();
    endtask
    task automatic t_ref();
        acc(1'b1, CMD_TRIM, 16'h0005, 1'b0, 16'h0);
        acc(1'b1, CMD_MARGIN_HIGH, 16'h000a, 1'b0, 16'h0);
        vsc <= 4'h2;
        op <= 8'h20;
        wait_ref(18'd215, 300);
        op <= 8'h30;
        wait_ref(18'd206, 40);
        vmax <= 18'd210;
        op <= 8'h20;
        wait_ref(18'd210, 40);
        // slow steady ramp must not arrive early
        seq <= SEQ_STEADY;
        trn <= 16'h0003;
        vmax <= 18'd300;
        repeat (10) @(posedge clk);
        chk(18'(rc > 18'd213), 18'h0);
        wait_ref(18'd215, 40);
    endtask
    task automatic t_nv();
        int i;
        @(posedge clk);
        sto <= 1'b1;
        @(posedge clk);
        sto <= 1'b0;
        for (i = 0; i < 4 && nvs !== 1'b1; i++) @(posedge clk);
        chk(18'(nvs), 18'h1);
        if (nvs !== 1'b1) end_of_test();
        chk(18'(nvo), 18'h5);
        nvt <= 16'h0007;
        mhs <= 1'b1;
        rsto <= 1'b1;
        @(posedge clk);
        rsto <= 1'b0;
        acc(1'b0, CMD_TRIM, 16'h0, 1'b0, 16'h0007);
        acc(1'b0, CMD_MARGIN_HIGH, 16'h0, 1'b0, 16'h000f);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {ls, mhs, mls, sto, rsto, clr, op, nvt, trn, ri, fi} = '0;
        rst = 1'b1;
        vcmd = 16'd100;
        vsc = 4'h1;
        vmax = 18'd300;
        vmin = 18'd0;
        seq = SEQ_SOFT_START;
        n_fail = 0;
        n_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_trim();
        t_mhi();
        t_slave();
        t_ref();
        t_nv();
        end_of_test();
    end
endmodule // tb
